// *** txso_core.v ***
// Operation
// - UDP sends are segmented exactly like TCP sends.
// - report-status bit keeps its normal handling inside segmentation requests.
// - completion interrupt only after descriptor buffer data reached the device.
// - payload split per context offsets, each frame gets fresh headers and checksums.
// - fetch a segment only when it fits in free packet-buffer space.
// - header bytes re-read from host for every segment; only descriptors cached.
// - zero threshold, head write-back off: each report-status descriptor written back.
// - zero threshold, no report-status, head write-back off: nothing written back.
// - zero threshold, no report-status, head write-back on: head written on timer expiry.
// - nonzero threshold, head write-back off: all descriptors burst back with done set.
// - head write-back on: head written for each report-status descriptor.
// - head write-back on: threshold ignored, treated as zero.
// - head-pointer writes are full 32-bit words.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "txso_defines.vh"
module txso_core (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output wire        irq,
	input  wire        descValid,
	output wire        descReady,
	input  wire        descCtx,
	input  wire        descHdr,
	input  wire        descRs,
	input  wire        descEop,
	input  wire [31:0] descAddr,
	input  wire [15:0] descLen,
	input  wire [15:0] ctxMss,
	input  wire [7:0]  ctxHdrLen,
	input  wire [17:0] ctxPayLen,
	input  wire        ctxUdp,
	input  wire        ctxIpv4,
	input  wire [17:0] pbFree,
	output reg         rdReq,
	output reg  [31:0] rdAddr,
	output reg  [17:0] rdLen,
	output reg         rdIsHdr,
	input  wire        rdAck,
	input  wire        rdDone,
	input  wire        dataValid,
	input  wire [15:0] dataWord,
	input  wire        dataIp,
	input  wire        dataL4,
	output reg         frmValid,
	output reg  [17:0] frmLen,
	output reg         frmLast,
	output reg         frmUdp,
	output reg         frmIpv4,
	output reg  [15:0] frmIpCsum,
	output reg  [15:0] frmL4Csum,
	output reg         frmPad,
	output reg         wrReq,
	output reg         wrHead,
	output reg  [31:0] wrAddr,
	output reg  [31:0] wrData,
	output wire [3:0]  wrSel,
	input  wire        wrAck,
	input  wire        eitrExpire
);
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_CHK  = 9'h002;
	localparam [8:0] S_HSEL = 9'h004;
	localparam [8:0] S_HRD  = 9'h008;
	localparam [8:0] S_PRD  = 9'h010;
	localparam [8:0] S_EMIT = 9'h020;
	localparam [8:0] S_CMPL = 9'h040;
	localparam [8:0] S_WB   = 9'h080;
	localparam [8:0] S_HWB  = 9'h100;

	function [17:0] fMin;
		input [17:0] a;
		input [17:0] b;
		begin
			fMin = (a < b) ? a : b;
		end
	endfunction

	reg  [8:0]  st_q;
	reg  [7:0]  ctrl_q;
	reg  [3:0]  stat_q;
	reg  [3:0]  mask_q;
	reg  [31:2] hwba_q;
	reg  [7:0]  head_q;
	reg  [7:0]  wbPtr_q;
	reg  [7:0]  wbIdx_q;
	reg  [7:0]  wbEnd_q;
	reg         wbFilt_q;
	reg  [7:0]  reqBase_q;
	reg  [2:0]  nDesc_q;
	reg  [5:0]  rsVec_q;
	reg  [5:0]  eopVec_q;
	reg  [2:0]  nHdr_q;
	reg  [1:0]  hIdx_q;
	reg  [7:0]  hRem_q;
	reg  [15:0] mss_q;
	reg  [7:0]  hdrLen_q;
	reg  [17:0] rem_q;
	reg  [31:0] payAddr_q;
	reg         udp_q;
	reg         ipv4_q;
	reg         rdWait_q;
	reg         eitrPend_q;
	reg  [7:0]  pend_q;
	reg  [3:0]  evt;
	wire [47:0] hEntry;
	wire [15:0] ipCsum;
	wire [15:0] l4Csum;

	wire       hwbEn  = ctrl_q[`TXSO_CTRL_HWB];
	wire [3:0] wth    = ctrl_q[`TXSO_CTRL_WTH_MSB:`TXSO_CTRL_WTH_LSB];
	// Head write-back forces threshold-zero behaviour
	wire       thrOn  = !hwbEn && wth != 4'h0;
	wire       busAcc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire       busWr  = busAcc && wb_we_i;
	wire [2:0] regIdx = wb_adr_i[4:2];
	wire [17:0] segLen = fMin(rem_q, {2'h0, mss_q});
	wire [17:0] hLen   = fMin({2'h0, hEntry[15:0]}, {10'h000, hRem_q});
	wire [2:0]  wbOff  = wbIdx_q[2:0] - reqBase_q[2:0];
	wire        wbNeed = !wbFilt_q || rsVec_q[wbOff];
	wire [7:0]  newHead = head_q + {5'h00, nDesc_q};
	wire        csClr  = st_q == S_CHK;

	assign descReady = (st_q == S_IDLE) && ctrl_q[`TXSO_CTRL_EN] && !eitrPend_q;
	assign wrSel     = 4'hF;
	assign irq       = |(stat_q & mask_q);

	txso_hdr_store uStore (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.wrEn     (descValid && descReady && descHdr && nHdr_q != `TXSO_MAX_HDR),
		.wrIdx    (nHdr_q[1:0]),
		.wrEntry  ({descAddr, descLen}),
		.rdIdx    (hIdx_q),
		.rdEntry  (hEntry)
	);

	// Same checksum path for TCP and UDP
	txso_csum uIpSum (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.clr      (csClr),
		.add      (dataValid && dataIp && ipv4_q),
		.word     (dataWord),
		.csum     (ipCsum)
	);
	txso_csum uL4Sum (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.clr      (csClr),
		.add      (dataValid && dataL4),
		.word     (dataWord),
		.csum     (l4Csum)
	);

	// Bus slave, one wait state, word indices 5-7 read zero; wb_adr_i[7:5] is ignored, so higher addresses alias the registers
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_q   <= `TXSO_CTRL_RST;
			mask_q   <= 4'h0;
			hwba_q   <= 30'h00000000;
		end else if (clkEn) begin
			wb_ack_o <= busAcc;
			if (busWr && wb_sel_i[0] && regIdx == `TXSO_REG_CTRL)
				ctrl_q <= wb_dat_i[7:0];
			if (busWr && wb_sel_i[0] && regIdx == `TXSO_REG_MASK)
				mask_q <= wb_dat_i[3:0];
			if (busWr && wb_sel_i == 4'hF && regIdx == `TXSO_REG_HWBA)
				hwba_q <= wb_dat_i[31:2];
			case (regIdx)
				`TXSO_REG_CTRL: wb_dat_o <= {24'h000000, ctrl_q};
				`TXSO_REG_STAT: wb_dat_o <= {28'h0000000, stat_q};
				`TXSO_REG_MASK: wb_dat_o <= {28'h0000000, mask_q};
				`TXSO_REG_HEAD: wb_dat_o <= {24'h000000, head_q};
				`TXSO_REG_HWBA: wb_dat_o <= {hwba_q, 2'h0};
				default:        wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// Events; set wins over a write-one clear
	always @* begin
		evt = 4'h0;
		evt[`TXSO_ST_SEG]  = st_q == S_EMIT;
		evt[`TXSO_ST_DONE] = st_q == S_CMPL;
		evt[`TXSO_ST_WB]   = (st_q == S_WB || st_q == S_HWB) && wrReq && wrAck;
		evt[`TXSO_ST_ERR]  = descValid && descReady && (
			(descCtx && !ctrl_q[`TXSO_CTRL_PAD]) ||
			(descHdr && nHdr_q == `TXSO_MAX_HDR) ||
			(hwbEn && descRs && !descEop && !descCtx && !descHdr));
		if (st_q == S_CMPL && hwbEn && |(rsVec_q & ~eopVec_q))
			evt[`TXSO_ST_ERR] = 1'b1;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			stat_q <= 4'h0;
		else if (clkEn) begin
			if (busWr && wb_sel_i[0] && regIdx == `TXSO_REG_STAT)
				stat_q <= (stat_q & ~wb_dat_i[3:0]) | evt;
			else
				stat_q <= stat_q | evt;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			head_q <= 8'h00;
			wbPtr_q <= 8'h00;
			wbIdx_q <= 8'h00;
			wbEnd_q <= 8'h00;
			wbFilt_q <= 1'b0;
			reqBase_q <= 8'h00;
			nDesc_q <= 3'h0;
			rsVec_q <= 6'h00;
			eopVec_q <= 6'h00;
			nHdr_q <= 3'h0;
			hIdx_q <= 2'h0;
			hRem_q <= 8'h00;
			mss_q <= 16'h0000;
			hdrLen_q <= 8'h00;
			rem_q <= 18'h00000;
			payAddr_q <= 32'h00000000;
			udp_q <= 1'b0;
			ipv4_q <= 1'b0;
			rdWait_q <= 1'b0;
			eitrPend_q <= 1'b0;
			pend_q <= 8'h00;
			rdReq <= 1'b0;
			rdAddr <= 32'h00000000;
			rdLen <= 18'h00000;
			rdIsHdr <= 1'b0;
			frmValid <= 1'b0;
			frmLen <= 18'h00000;
			frmLast <= 1'b0;
			frmUdp <= 1'b0;
			frmIpv4 <= 1'b0;
			frmIpCsum <= 16'h0000;
			frmL4Csum <= 16'h0000;
			frmPad <= 1'b0;
			wrReq <= 1'b0;
			wrHead <= 1'b0;
			wrAddr <= 32'h00000000;
			wrData <= 32'h00000000;
		end else if (clkEn) begin
			frmValid <= 1'b0;
			if (eitrExpire)
				eitrPend_q <= 1'b1;
			case (st_q)
				S_IDLE: begin
					if (eitrPend_q) begin
						eitrPend_q <= eitrExpire;
						if (hwbEn) begin
							wrReq <= 1'b1;
							wrHead <= 1'b1;
							wrAddr <= {hwba_q, 2'h0};
							wrData <= {24'h000000, head_q};
							st_q <= S_HWB;
						end else if (thrOn && pend_q != 8'h00) begin
							wbIdx_q <= wbPtr_q;
							wbEnd_q <= head_q;
							wbFilt_q <= 1'b0;
							pend_q <= 8'h00;
							st_q <= S_WB;
						end
					end else if (descValid && descReady) begin
						rsVec_q[nDesc_q] <= descRs;
						eopVec_q[nDesc_q] <= descEop;
						nDesc_q <= nDesc_q + 3'h1;
						if (descCtx) begin
							reqBase_q <= head_q;
							nDesc_q <= 3'h1;
							rsVec_q <= {5'h00, descRs};
							eopVec_q <= {5'h00, descEop};
							nHdr_q <= 3'h0;
							mss_q <= ctxMss;
							hdrLen_q <= ctxHdrLen;
							rem_q <= ctxPayLen;
							udp_q <= ctxUdp;
							ipv4_q <= ctxIpv4;
						end else if (descHdr) begin
							if (nHdr_q != `TXSO_MAX_HDR)
								nHdr_q <= nHdr_q + 3'h1;
						end else begin
							payAddr_q <= descAddr;
							st_q <= S_CHK;
						end
					end
				end
				S_CHK: begin
					if (pbFree >= segLen + {10'h000, hdrLen_q}) begin
						hIdx_q <= 2'h0;
						hRem_q <= hdrLen_q;
						st_q <= (nHdr_q == 3'h0) ? S_PRD : S_HSEL;
					end
				end
				S_HSEL: st_q <= S_HRD;
				S_HRD: begin
					if (!rdReq && !rdWait_q) begin
						rdReq <= 1'b1;
						rdAddr <= hEntry[47:16];
						rdLen <= hLen;
						rdIsHdr <= 1'b1;
					end else if (rdReq && rdAck) begin
						rdReq <= 1'b0;
						rdWait_q <= 1'b1;
					end else if (rdWait_q && rdDone) begin
						rdWait_q <= 1'b0;
						hRem_q <= hRem_q - rdLen[7:0];
						hIdx_q <= hIdx_q + 2'h1;
						if ({1'b0, hIdx_q} + 3'h1 == nHdr_q || rdLen[7:0] == hRem_q)
							st_q <= S_PRD;
						else
							st_q <= S_HSEL;
					end
				end
				S_PRD: begin
					if (!rdReq && !rdWait_q) begin
						rdReq <= 1'b1;
						rdAddr <= payAddr_q;
						rdLen <= segLen;
						rdIsHdr <= 1'b0;
					end else if (rdReq && rdAck) begin
						rdReq <= 1'b0;
						rdWait_q <= 1'b1;
					end else if (rdWait_q && rdDone) begin
						rdWait_q <= 1'b0;
						payAddr_q <= payAddr_q + {14'h0000, rdLen};
						rem_q <= rem_q - rdLen;
						st_q <= S_EMIT;
					end
				end
				S_EMIT: begin
					frmValid <= 1'b1;
					frmLen <= rdLen + {10'h000, hdrLen_q};
					frmLast <= rem_q == 18'h00000;
					frmUdp <= udp_q;
					frmIpv4 <= ipv4_q;
					frmIpCsum <= ipv4_q ? ipCsum : 16'h0000;
					frmL4Csum <= l4Csum;
					frmPad <= ctrl_q[`TXSO_CTRL_PAD];
					st_q <= (rem_q == 18'h00000) ? S_CMPL : S_CHK;
				end
				S_CMPL: begin
					// Last segment fetched: header slots may now be released
					head_q <= newHead;
					st_q <= S_IDLE;
					if (hwbEn) begin
						if (|rsVec_q) begin
							wrReq <= 1'b1;
							wrHead <= 1'b1;
							wrAddr <= {hwba_q, 2'h0};
							wrData <= {24'h000000, newHead};
							st_q <= S_HWB;
						end
					end else if (!thrOn) begin
						if (|rsVec_q) begin
							wbIdx_q <= head_q;
							wbEnd_q <= newHead;
							wbFilt_q <= 1'b1;
							st_q <= S_WB;
						end
					end else if (pend_q + {5'h00, nDesc_q} >= {4'h0, wth}) begin
						wbIdx_q <= wbPtr_q;
						wbEnd_q <= newHead;
						wbFilt_q <= 1'b0;
						pend_q <= 8'h00;
						st_q <= S_WB;
					end else
						pend_q <= pend_q + {5'h00, nDesc_q};
				end
				S_WB: begin
					if (wbIdx_q == wbEnd_q) begin
						wbPtr_q <= wbEnd_q;
						st_q <= S_IDLE;
					end else if (!wrReq) begin
						if (wbNeed) begin
							wrReq <= 1'b1;
							wrHead <= 1'b0;
							wrAddr <= {24'h000000, wbIdx_q};
							wrData <= `TXSO_DD_WORD;
						end else
							wbIdx_q <= wbIdx_q + 8'h01;
					end else if (wrAck) begin
						wrReq <= 1'b0;
						wbIdx_q <= wbIdx_q + 8'h01;
					end
				end
				S_HWB: begin
					if (wrAck) begin
						wrReq <= 1'b0;
						wrHead <= 1'b0;
						wbPtr_q <= head_q;
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // txso_core
`default_nettype wire

// *** txso_defines.vh ***
`ifndef TXSO_DEFINES_VH
`define TXSO_DEFINES_VH
// Register word indices (byte address = index * 4)
`define TXSO_REG_CTRL     3'h0
`define TXSO_REG_STAT     3'h1
`define TXSO_REG_MASK     3'h2
`define TXSO_REG_HEAD     3'h3
`define TXSO_REG_HWBA     3'h4
// Control fields
`define TXSO_CTRL_EN      0
`define TXSO_CTRL_PAD     1
`define TXSO_CTRL_HWB     2
`define TXSO_CTRL_WTH_LSB 4
`define TXSO_CTRL_WTH_MSB 7
`define TXSO_CTRL_RST     8'h00
// Status and mask bits, and their width
`define TXSO_ST_SEG       0
`define TXSO_ST_DONE      1
`define TXSO_ST_WB        2
`define TXSO_ST_ERR       3
`define TXSO_ST_W         4
// Sizes and the write-back done word
`define TXSO_MAX_HDR      3'h4
`define TXSO_RING_W       8
`define TXSO_LEN_W        18
`define TXSO_DD_WORD      32'h00000001
`endif

// *** txso_hdr_store.v ***
`timescale 1ns/1ns
`default_nettype none
module txso_hdr_store (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        wrEn,
	input  wire [1:0]  wrIdx,
	input  wire [47:0] wrEntry,
	input  wire [1:0]  rdIdx,
	output reg  [47:0] rdEntry
);
	reg [47:0] mem [0:3];
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gEnt
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					mem[g] <= 48'h000000000000;
				else if (clkEn && wrEn && wrIdx == g)
					mem[g] <= wrEntry;
			end
		end
	endgenerate
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rdEntry <= 48'h000000000000;
		else if (clkEn)
			rdEntry <= mem[rdIdx];
	end
endmodule // txso_hdr_store
`default_nettype wire

// *** txso_csum.v ***
`timescale 1ns/1ns
`default_nettype none
module txso_csum (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        clr,
	input  wire        add,
	input  wire [15:0] word,
	output wire [15:0] csum
);
	reg  [15:0] sum_q;
	wire [16:0] raw = {1'b0, sum_q} + {1'b0, word};
	// End-around carry keeps one's complement arithmetic
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sum_q <= 16'h0000;
		else if (clkEn) begin
			if (clr)
				sum_q <= 16'h0000;
			else if (add)
				sum_q <= raw[15:0] + {15'h0000, raw[16]};
		end
	end
	assign csum = ~sum_q;
endmodule // txso_csum
`default_nettype wire

// *** txso_core_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module txso_core_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        clkEn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        rdReq,
	input wire logic        rdAck,
	input wire logic [31:0] rdAddr,
	input wire logic [17:0] rdLen,
	input wire logic        frmValid,
	input wire logic        frmIpv4,
	input wire logic [15:0] frmIpCsum,
	input wire logic        wrReq,
	input wire logic        wrAck,
	input wire logic        wrHead,
	input wire logic [31:0] wrAddr,
	input wire logic [31:0] wrData,
	input wire logic [3:0]  wrSel
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	AST_WR_FULL_WORD: assert property (wrReq |-> wrSel == 4'hF)
		else $error("write port not a full word");
	AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
		else $error("bus ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	AST_RD_HOLD: assert property (rdReq && !rdAck |=> rdReq && $stable(rdAddr) && $stable(rdLen))
		else $error("read request dropped early");
	AST_WR_HOLD: assert property (wrReq && !wrAck |=> wrReq && $stable(wrAddr) && $stable(wrData))
		else $error("write request dropped early");
	AST_FRM_PULSE: assert property ($rose(frmValid) |=> !frmValid)
		else $error("frame strobe too long");
	AST_FRM_AFTER_FETCH: assert property (frmValid |-> !rdReq)
		else $error("frame emitted with fetch pending");
	AST_IP_CSUM_ZERO: assert property (frmValid && !frmIpv4 |-> frmIpCsum == 16'h0000)
		else $error("ip checksum on non ipv4 frame");
	AST_DONE_WORD: assert property (wrReq && !wrHead |-> wrData == 32'h00000001)
		else $error("write-back without done");
	COV_FRAME: cover property (frmValid);
	COV_HEAD_WR: cover property (wrReq && wrHead && wrAck);
	COV_DESC_WR: cover property (wrReq && !wrHead && wrAck);
endmodule // txso_core_sva
bind txso_core txso_core_sva chk (.*);
`default_nettype wire

// *** txso_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module txso_host_model (
	input  wire logic        core_clk,
	input  wire logic        slowMode,
	input  wire logic        rdReq,
	input  wire logic        rdIsHdr,
	output var  logic        rdAck,
	output var  logic        rdDone,
	output var  logic        dataValid,
	output var  logic [15:0] dataWord,
	output var  logic        dataIp,
	output var  logic        dataL4,
	input  wire logic        wrReq,
	input  wire logic        wrHead,
	input  wire logic [31:0] wrAddr,
	input  wire logic [31:0] wrData,
	output var  logic        wrAck,
	output var  logic [31:0] hdrReads,
	output var  logic [31:0] wrCount,
	output var  logic [31:0] lastAddr,
	output var  logic [31:0] lastData,
	output var  logic        lastHead
);
	initial begin
		{rdAck, rdDone, dataValid, dataIp, dataL4} = 5'h00;
		dataWord = 16'h0000;
		hdrReads = 32'h0;
		forever begin
			@(posedge core_clk);
			if (rdReq === 1'b1) begin
				if (slowMode) repeat (3) @(posedge core_clk);
				rdAck <= 1'b1;
				dataIp <= rdIsHdr;
				hdrReads = hdrReads + {31'h0, rdIsHdr};
				@(posedge core_clk);
				rdAck <= 1'b0;
				dataValid <= 1'b1;
				dataWord <= 16'h4500;
				dataL4 <= 1'b1;
				@(posedge core_clk);
				dataValid <= 1'b0;
				dataWord <= ~dataWord;
				rdDone <= 1'b1;
				@(posedge core_clk);
				rdDone <= 1'b0;
			end
		end
	end
	initial begin
		wrAck = 1'b0;
		wrCount = 32'h0;
		forever begin
			@(posedge core_clk);
			if (wrReq === 1'b1) begin
				if (slowMode) repeat (2) @(posedge core_clk);
				wrAck <= 1'b1;
				wrCount = wrCount + 32'h1;
				lastHead = wrHead;
				lastAddr = wrAddr;
				lastData = wrData;
				@(posedge core_clk);
				wrAck <= 1'b0;
			end
		end
	end
endmodule // txso_host_model
`default_nettype wire

// *** tb_tx_segmentation_offload.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_tx_segmentation_offload;
	logic        core_clk, rst_n, clkEn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, slowMode, eitrExpire;
	logic        descValid, descReady, descCtx, descHdr, descRs, descEop, ctxUdp, ctxIpv4, expUdp;
	logic        rdReq, rdIsHdr, rdAck, rdDone, dataValid, dataIp, dataL4, wrReq, wrHead, wrAck, lastHead;
	logic        frmValid, frmLast, frmUdp, frmIpv4, frmPad;
	logic [7:0]  wb_adr_i, ctxHdrLen;
	logic [3:0]  wb_sel_i, wrSel;
	logic [15:0] descLen, ctxMss, dataWord, frmIpCsum, frmL4Csum;
	logic [17:0] ctxPayLen, pbFree, rdLen, frmLen;
	logic [31:0] wb_dat_i, wb_dat_o, descAddr, rdAddr, wrAddr, wrData, r, expHdr;
	logic [31:0] hdrReads, wrCount, lastAddr, lastData, frmCount, numErrors, totalChecks;
	txso_core dut (.*);
	txso_host_model host (.*);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic cmpVal(input [31:0] got, input [31:0] exp);
		totalChecks = totalChecks + 1;
		if (got !== exp) begin
			numErrors = numErrors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task endOfTest;
		$display("checks=%0d errors=%0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wbAcc(input w, input [7:0] a, input [31:0] d);
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge core_clk);
		while (wb_ack_o !== 1'b1) @(posedge core_clk);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	task sendDesc(input c, input h, input rs, input [15:0] len);
		@(posedge core_clk);
		{descValid, descCtx, descHdr, descRs, descEop} <= {2'b11 & {1'b1, c}, h, rs, !c && !h};
		descLen <= len;
		descAddr <= descAddr + 32'h40;
		@(posedge core_clk);
		while (descReady !== 1'b1) @(posedge core_clk);
		descValid <= 1'b0;
	endtask
	task runReq(input udp, input rs);
		ctxUdp <= udp;
		expUdp = udp;
		sendDesc(1'b1, 1'b0, 1'b0, 16'h0000);
		sendDesc(1'b0, 1'b1, 1'b0, 16'h0008);
		expHdr = descAddr;
		sendDesc(1'b0, 1'b0, rs, 16'h0028);
	endtask
	always @(posedge core_clk) begin
		if (rdReq === 1'b1 && rdAck === 1'b1 && rdIsHdr === 1'b1)
			cmpVal(rdAddr, expHdr);
		if (frmValid === 1'b1) begin
			frmCount = frmCount + 1;
			cmpVal({12'h000, frmLast, frmUdp, frmLen}, {12'h000, frmCount % 3 == 0, expUdp, (frmCount % 3 == 0) ? 18'h10 : 18'h18});
			cmpVal({frmIpCsum, frmL4Csum}, {ctxIpv4 ? 16'hBAFF : 16'h0000, 16'h75FF});
			cmpVal({30'h0, frmIpv4, frmPad}, {30'h0, ctxIpv4, 1'b1});
		end
	end
	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, descValid, descCtx, descHdr, descRs, descEop, eitrExpire} = 10'h000;
		{clkEn, ctxIpv4, slowMode, ctxUdp, expUdp} = 5'h18;
		{wb_adr_i, wb_dat_i, descAddr, descLen} = 88'h0;
		{wb_sel_i, ctxMss, ctxHdrLen, ctxPayLen, pbFree} = {4'hF, 16'h0010, 8'h08, 18'h00028, 18'h0000A};
		{frmCount, numErrors, totalChecks} = 96'h0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (i != 4) wbAcc(1'b0, 8'(i * 4), 32'h0);
			if (i != 4) cmpVal(r, 32'h0);
		end
		wbAcc(1'b1, 8'h00, 32'h00000003);
		wbAcc(1'b1, 8'h08, 32'h00000002);
		runReq(1'b0, 1'b1);
		repeat (40) @(posedge core_clk);
		cmpVal(hdrReads + frmCount, 32'h0);
		clkEn <= 1'b0;
		pbFree <= 18'h3FFFF;
		repeat (10) @(posedge core_clk);
		cmpVal(hdrReads + frmCount, 32'h0);
		clkEn <= 1'b1;
		while (wrCount < 1) @(posedge core_clk);
		cmpVal(frmCount, 32'h3);
		cmpVal(hdrReads, 32'h3);
		cmpVal({lastHead, lastAddr, lastData}, {1'b0, 32'h2, 32'h1});
		wbAcc(1'b0, 8'h0C, 32'h0);
		cmpVal(r, 32'h3);
		wbAcc(1'b0, 8'h04, 32'h0);
		cmpVal(r, 32'h7);
		cmpVal({31'h0, irq}, 32'h1);
		wbAcc(1'b1, 8'h04, 32'h0000000F);
		cmpVal({31'h0, irq}, 32'h0);
		slowMode <= 1'b1;
		wbAcc(1'b1, 8'h10, 32'h00000100);
		wbAcc(1'b1, 8'h00, 32'h00000047);
		runReq(1'b1, 1'b1);
		while (wrCount < 2) @(posedge core_clk);
		cmpVal({lastHead, lastAddr, lastData}, {1'b1, 32'h100, 32'h6});
		wbAcc(1'b1, 8'h00, 32'h00000003);
		ctxIpv4 <= 1'b0;
		runReq(1'b0, 1'b0);
		while (frmCount < 9) @(posedge core_clk);
		repeat (30) @(posedge core_clk);
		cmpVal(wrCount, 32'h2);
		wbAcc(1'b0, 8'h0C, 32'h0);
		cmpVal(r, 32'h9);
		wbAcc(1'b1, 8'h00, 32'h00000007);
		@(posedge core_clk);
		eitrExpire <= 1'b1;
		@(posedge core_clk);
		eitrExpire <= 1'b0;
		while (wrCount < 3) @(posedge core_clk);
		cmpVal({lastHead, lastAddr, lastData}, {1'b1, 32'h100, 32'h9});
		wbAcc(1'b1, 8'h00, 32'h00000013);
		runReq(1'b1, 1'b0);
		while (wrCount < 6) @(posedge core_clk);
		cmpVal({lastHead, lastAddr, lastData}, {1'b0, 32'hB, 32'h1});
		endOfTest;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		numErrors = numErrors + 1;
		endOfTest;
	end
endmodule // tb_tx_segmentation_offload
`default_nettype wire
